/* hw/ssadc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module ssadc_ctrl (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire ssadc_pkg::ssadc_bus_t bus,
   output logic [7:0]             rdata,
   input  wire logic              aux_cmp_in,
   input  wire logic              ramp_cmp_in,
   input  wire logic              capture_input_pin,
   input  wire logic              capture_event,
   input  wire logic              compare_event,
   output ssadc_pkg::ssadc_route_t route,
   output ssadc_pkg::ssadc_ramp_t  ramp,
   output logic                   aux_comparator_power,
   output logic                   ramp_comparator_power,
   output logic                   comparator_swap,
   output logic                   timer_capture_in,
   output logic                   analog_irq
);
   // ****************************************
   // registers
   // ****************************************
   logic [7:0] ctl_q;
   logic [7:0] chan_q;
   logic [2:0] aux_sync_q;
   logic [2:0] ramp_sync_q;
   logic       aux_cmp_flag_q;
   logic       ramp_cmp_flag_q;
   logic       wr_ctl;
   logic       wr_chan;
   logic       wr_stat;
   logic       aux_rise;
   logic       ramp_rise;
   logic       aux_flag_clear;
   logic       ramp_flag_clear;
   logic [1:0] mode;
   logic [2:0] cap_sync_q;
   logic       aux_live_q;
   logic       ramp_live_q;
   logic       cap_live_q;

   // ****************************************
   // helpers
   // ****************************************
   // write strobe aimed at one register
   function automatic logic addr_hit(input ssadc_pkg::ssadc_bus_t b,
                                     input logic [7:0]            a);
      return b.wr && (b.addr == a);
   endfunction

   // stages two and three agree
   function automatic logic settled(input logic [2:0] s);
      return s[ssadc_pkg::SYNC_STAGES-2] == s[ssadc_pkg::SYNC_STAGES-1];
   endfunction

   // agreed high while held level still low
   function automatic logic rose(input logic [2:0] s,
                                 input logic       live);
      return settled(s) && s[ssadc_pkg::SYNC_STAGES-1] && !live;
   endfunction

   // no channel pin selected
   function automatic logic no_pins(input logic [7:0] ch);
      return ch[ssadc_pkg::CH_PIN4:ssadc_pkg::CH_PIN1] == 4'h0;
   endfunction

   // status word; clear bits read zero
   function automatic logic [7:0] status_word(input logic rf,
                                              input logic af,
                                              input logic rl,
                                              input logic al);
      logic [7:0] w;
      w = 8'h00;
      w[ssadc_pkg::ST_RAMP_FLAG] = rf;
      w[ssadc_pkg::ST_AUX_FLAG]  = af;
      w[ssadc_pkg::ST_RAMP_LIVE] = rl;
      w[ssadc_pkg::ST_AUX_LIVE]  = al;
      return w;
   endfunction

   assign wr_ctl  = addr_hit(bus, ssadc_pkg::ADDR_CONTROL);
   assign wr_chan = addr_hit(bus, ssadc_pkg::ADDR_CHANNEL);
   assign wr_stat = addr_hit(bus, ssadc_pkg::ADDR_STATUS);
   assign aux_flag_clear  = wr_stat && bus.wdata[ssadc_pkg::ST_AUX_CLR];
   assign ramp_flag_clear = wr_stat && bus.wdata[ssadc_pkg::ST_RAMP_CLR];
   assign mode = {ctl_q[ssadc_pkg::CTL_MODE1], ctl_q[ssadc_pkg::CTL_MODE0]};

   // ****************************************
   // comparator synchronisers
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_sync_q  <= 3'h0;
         ramp_sync_q <= 3'h0;
      end else begin
         aux_sync_q  <= {aux_sync_q[1:0], aux_cmp_in};
         ramp_sync_q <= {ramp_sync_q[1:0], ramp_cmp_in};
      end
   end

   // ****************************************
   // capture pin synchroniser
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cap_sync_q <= 3'h0;
      end else begin
         cap_sync_q <= {cap_sync_q[1:0], capture_input_pin};
      end
   end

   // change counts once stages two and three agree
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_live_q  <= 1'b0;
         ramp_live_q <= 1'b0;
         cap_live_q  <= 1'b0;
      end else begin
         if (settled(aux_sync_q)) begin
            aux_live_q <= aux_sync_q[2];
         end
         if (settled(ramp_sync_q)) begin
            ramp_live_q <= ramp_sync_q[2];
         end
         if (settled(cap_sync_q)) begin
            cap_live_q <= cap_sync_q[2];
         end
      end
   end
   assign aux_rise  = rose(aux_sync_q, aux_live_q);
   assign ramp_rise = rose(ramp_sync_q, ramp_live_q);

   // ****************************************
   // comparator flags
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_cmp_flag_q  <= 1'b0;
         ramp_cmp_flag_q <= 1'b0;
      end else begin
         // any rising edge counts, swap-induced included; set beats clear
         if (aux_rise) begin
            aux_cmp_flag_q <= 1'b1;
         end else if (aux_flag_clear) begin
            aux_cmp_flag_q <= 1'b0;
         end
         if (ramp_rise) begin
            ramp_cmp_flag_q <= 1'b1;
         end else if (ramp_flag_clear) begin
            ramp_cmp_flag_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // control register
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl_q <= ssadc_pkg::CONTROL_RESET;
      end else begin
         if (wr_ctl) begin
            ctl_q <= bus.wdata;
            if (bus.wdata[ssadc_pkg::CTL_MODE1]) begin
               ctl_q[ssadc_pkg::CTL_CAPSEL] <= 1'b1;
            end
         end else if (ctl_q[ssadc_pkg::CTL_RAMP_PWR]) begin
            // automatic charge control only with ramp power
            if (mode[1] && ctl_q[ssadc_pkg::CTL_CHARGE] && capture_event) begin
               ctl_q[ssadc_pkg::CTL_CHARGE] <= 1'b0;
            end else if ((mode == 2'h3) && !ctl_q[ssadc_pkg::CTL_CHARGE]
                         && compare_event) begin
               ctl_q[ssadc_pkg::CTL_CHARGE] <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // channel select register
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         chan_q <= ssadc_pkg::CHANNEL_RESET;
      end else if (wr_chan) begin
         chan_q <= bus.wdata;
      end
   end

   // ****************************************
   // routing and ramp drive
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         route <= '{vdd_on: 1'b0, gnd_on: 1'b1, pin_on: 4'h0};
      end else begin
         route.pin_on <= chan_q[ssadc_pkg::CH_PIN4:ssadc_pkg::CH_PIN1];
         route.vdd_on <= chan_q[ssadc_pkg::CH_VREF] && no_pins(chan_q);
         route.gnd_on <= !chan_q[ssadc_pkg::CH_VREF] && no_pins(chan_q);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ramp <= '{source_on: 1'b0, sink_on: 1'b0};
      end else begin
         // ramp power gates both source and sink
         ramp.source_on <= ctl_q[ssadc_pkg::CTL_RAMP_PWR]
                           && ctl_q[ssadc_pkg::CTL_CHARGE];
         ramp.sink_on   <= ctl_q[ssadc_pkg::CTL_RAMP_PWR]
                           && !ctl_q[ssadc_pkg::CTL_CHARGE];
      end
   end

   // ****************************************
   // power, capture routing, interrupt
   // ****************************************
   // comparator power and swap
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_comparator_power  <= 1'b0;
         ramp_comparator_power <= 1'b0;
         comparator_swap       <= 1'b0;
      end else begin
         aux_comparator_power  <= ctl_q[ssadc_pkg::CTL_AUX_PWR];
         ramp_comparator_power <= ctl_q[ssadc_pkg::CTL_RAMPC_PWR];
         comparator_swap       <= chan_q[ssadc_pkg::CH_SWAP];
      end
   end

   // capture routing
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         timer_capture_in <= 1'b0;
      end else begin
         // ramp flag level (capture select set) or settled pin level drives capture; timer edge logic finds the rise
         timer_capture_in <= ctl_q[ssadc_pkg::CTL_CAPSEL] ? ramp_cmp_flag_q
                                                          : cap_live_q;
      end
   end

   // interrupt request
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         analog_irq <= 1'b0;
      end else begin
         // level request, independent of timer capture flag
         analog_irq <= ctl_q[ssadc_pkg::CTL_IRQ_EN]
                       && (aux_cmp_flag_q || ramp_cmp_flag_q);
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            ssadc_pkg::ADDR_CONTROL: rdata <= ctl_q;
            ssadc_pkg::ADDR_CHANNEL: rdata <= chan_q;
            ssadc_pkg::ADDR_STATUS: begin
               rdata <= status_word(ramp_cmp_flag_q, aux_cmp_flag_q,
                                    ramp_live_q, aux_live_q);
            end
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* hw/ssadc_pkg.sv */
// Behaviour
// - comparator swap changes may set either flag; flags accept them as real edges.
// - supply reference drives bus only when set and no channel pin selected.
// - four channel pin selects are independent; any combination routes together.
// - select n routes pin n; nothing selected means ground drives bus.
// - control register holds ramp and two comparator power enables.
// - reset clears every control bit, powering analog parts down.
// - powered ramp: charge one sources current, zero enables discharge sink.
// - reading charge returns live state including hardware changes.
// - two mode bits pick one of four modes; ignored without ramp power.
// - reset clears mode bits, giving manual mode.
// - ramp power clear: pin neither sources nor sinks current.
// - manual mode: charge follows software set and clear.
// - upper mode bit set: capture event clears a set charge bit.
// - mode 3: compare event sets a cleared charge bit.
// - capture select feeds ramp flag to timer capture, else capture pin.
// - setting upper mode bit sets capture select; reset clears it.
// - comparator capture stores end time in timer's 16-bit capture buffer.
// - irq enable set: analog interrupt while either comparator flag set.
// - one ramp edge raises capture and analog interrupts; analog one clock first.
// - analog interrupt stays pending until its comparator flag is cleared.
// - each flag set by rising comparator edge, held until cleared.
// - writing one to flag clear clears flag; zero no effect; reads zero.
// - ramp power enables both current source and discharge device.
`default_nettype none
package ssadc_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_CONTROL = 8'h1D;
   localparam logic [7:0] ADDR_CHANNEL = 8'h1C;
   localparam logic [7:0] ADDR_STATUS  = 8'h1E;
   // ****************************************
   // control fields
   // ****************************************
   localparam int CTL_CHARGE    = 7;
   localparam int CTL_MODE1     = 6;
   localparam int CTL_MODE0     = 5;
   localparam int CTL_CAPSEL    = 4;
   localparam int CTL_IRQ_EN    = 3;
   localparam int CTL_RAMP_PWR  = 2;
   localparam int CTL_AUX_PWR   = 1;
   localparam int CTL_RAMPC_PWR = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // ****************************************
   // channel select fields
   // ****************************************
   localparam int CH_SWAP = 5;
   localparam int CH_VREF = 4;
   localparam int CH_PIN4 = 3;
   localparam int CH_PIN1 = 0;
   localparam logic [7:0] CHANNEL_RESET = 8'h00;
   // ****************************************
   // status fields
   // ****************************************
   localparam int ST_RAMP_FLAG  = 7;
   localparam int ST_AUX_FLAG   = 6;
   localparam int ST_RAMP_CLR   = 5;
   localparam int ST_AUX_CLR    = 4;
   localparam int ST_RAMP_LIVE  = 1;
   localparam int ST_AUX_LIVE   = 0;
   localparam int SYNC_STAGES   = 3;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ssadc_bus_t;

   typedef struct packed {
      logic       vdd_on;
      logic       gnd_on;
      logic [3:0] pin_on;
   } ssadc_route_t;

   typedef struct packed {
      logic source_on;
      logic sink_on;
   } ssadc_ramp_t;
endpackage
`default_nettype wire

/* test/ssadc_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checks
// ****************************************
module ssadc_ctrl_assertions (
   input wire logic                    clk,
   input wire logic                    reset,
   input wire ssadc_pkg::ssadc_bus_t   bus,
   input wire logic [7:0]              rdata,
   input wire logic                    capture_input_pin,
   input wire ssadc_pkg::ssadc_route_t route,
   input wire ssadc_pkg::ssadc_ramp_t  ramp,
   input wire logic                    timer_capture_in,
   input wire logic                    analog_irq
);
   logic wc;
   logic wh;
   assign wc = bus.wr && bus.addr == ssadc_pkg::ADDR_CONTROL;
   assign wh = bus.wr && bus.addr == ssadc_pkg::ADDR_CHANNEL;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_not_both; !(ramp.source_on && ramp.sink_on); endproperty
   property p_gnd; route.gnd_on == (!route.vdd_on && route.pin_on == 4'h0); endproperty
   property p_vdd; route.vdd_on |-> route.pin_on == 4'h0; endproperty
   property p_pins; wh |-> ##2 {4'h0, route.pin_on} == ($past(bus.wdata, 2) & 8'h0F); endproperty
   property p_off; wc && !bus.wdata[2] |-> ##2 !ramp.source_on && !ramp.sink_on; endproperty
   property p_manual; wc && bus.wdata[7:5] == 3'h4 && bus.wdata[2] |-> ##2 ramp.source_on;
   endproperty
   property p_irq_off; wc && !bus.wdata[3] |-> ##2 !analog_irq; endproperty
   property p_pin_cap; (wc && !bus.wdata[4] && !bus.wdata[6]) ##1 (!wc)[*7]
      |-> timer_capture_in == $past(capture_input_pin, 5); endproperty
   property p_clr_zero; bus.rd && bus.addr == ssadc_pkg::ADDR_STATUS |=> rdata[5:4] == 2'h0;
   endproperty
   a_not_both: assert property (p_not_both) else $error("source and sink both on");
   a_gnd: assert property (p_gnd) else $error("ground switch wrong");
   a_vdd: assert property (p_vdd) else $error("supply with pin selected");
   a_pins: assert property (p_pins) else $error("pin switches wrong");
   a_off: assert property (p_off) else $error("ramp current unpowered");
   a_manual: assert property (p_manual) else $error("manual charge missing");
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   a_pin_cap: assert property (p_pin_cap) else $error("capture not from pin");
   a_clr_zero: assert property (p_clr_zero) else $error("clear bits read one");
   c_charge_end: cover property ($fell(ramp.source_on));
   c_irq: cover property ($rose(analog_irq));
   c_vdd: cover property ($rose(route.vdd_on));
endmodule
bind ssadc_ctrl ssadc_ctrl_assertions chk_u (.clk(clk), .reset(reset), .bus(bus),
   .rdata(rdata), .capture_input_pin(capture_input_pin), .route(route), .ramp(ramp),
   .timer_capture_in(timer_capture_in), .analog_irq(analog_irq));
`default_nettype wire

/* test/ssadc_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ssadc_ctrl_tb_top;
   // ****************************************
   // bench
   // ****************************************
   logic                    clk = 1'b0;
   logic                    reset = 1'b1;
   ssadc_pkg::ssadc_bus_t   bus = '0;
   logic [7:0]              rdata;
   logic                    aux_in = 1'b0;
   logic                    ramp_in = 1'b0;
   logic                    cap_pin = 1'b0;
   logic                    cmp_req = 1'b0;
   logic                    cap_ev;
   logic                    cmp_ev;
   ssadc_pkg::ssadc_route_t route;
   ssadc_pkg::ssadc_ramp_t  ramp;
   logic                    aux_pwr;
   logic                    ramp_pwr;
   logic                    swap;
   logic                    tcap;
   logic                    irq;
   int                      n_errors = 0;
   int                      checks = 0;
   int                      i;
   always #4 clk = ~clk;
   ssadc_ctrl dut_u (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .aux_cmp_in(aux_in),
      .ramp_cmp_in(ramp_in), .capture_input_pin(cap_pin), .capture_event(cap_ev),
      .compare_event(cmp_ev), .route(route), .ramp(ramp), .aux_comparator_power(aux_pwr),
      .ramp_comparator_power(ramp_pwr), .comparator_swap(swap), .timer_capture_in(tcap),
      .analog_irq(irq));
   ssadc_timer_model tmr_u (.clk(clk), .reset(reset), .capture_in(tcap),
      .compare_req(cmp_req), .capture_event(cap_ev), .compare_event(cmp_ev));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= {1'b1, 1'b0, a, d};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= {1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      bus <= '0;
      #1 chk(rdata, exp);
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic bound();
      if (i >= 40) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   task automatic t_reset();
      rd(ssadc_pkg::ADDR_CONTROL, 8'h00);
      rd(ssadc_pkg::ADDR_STATUS, 8'h00);
      rd(8'h00, 8'h00);
      chk({route, ramp}, 8'h40);
   endtask
   task automatic t_route();
      logic [7:0] e;
      for (int k = 0; k < 32; k++) begin
         e = {2'h0, k[4] & ~|k[3:0], ~|k[4:0], k[3:0]};
         wr(ssadc_pkg::ADDR_CHANNEL, k[7:0]);
         settle();
         chk({2'h0, route}, e);
      end
      rd(ssadc_pkg::ADDR_CHANNEL, 8'h1F);
   endtask
   task automatic t_ramp();
      wr(ssadc_pkg::ADDR_CONTROL, 8'h80);
      settle();
      chk({4'h0, ramp, aux_pwr, ramp_pwr}, 8'h00);
      wr(ssadc_pkg::ADDR_CONTROL, 8'h87);
      settle();
      chk({4'h0, ramp, aux_pwr, ramp_pwr}, 8'h0B);
      wr(ssadc_pkg::ADDR_CONTROL, 8'h04);
      settle();
      chk({4'h0, ramp, aux_pwr, ramp_pwr}, 8'h04);
      @(posedge clk);
      cap_pin <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk(tcap, 1'b1);
   endtask
   task automatic t_mode2();
      wr(ssadc_pkg::ADDR_CONTROL, 8'hCC);
      rd(ssadc_pkg::ADDR_CONTROL, 8'hDC);
      chk({6'h0, ramp}, 8'h02);
      ramp_in <= 1'b1;
      for (i = 0; i < 40 && ramp.source_on !== 1'b0; i++) @(posedge clk);
      bound();
      #1 chk({5'h0, ramp, irq}, 8'h03);
      rd(ssadc_pkg::ADDR_CONTROL, 8'h5C);
      ramp_in <= 1'b0;
      wr(ssadc_pkg::ADDR_STATUS, 8'h00);
      repeat (6) @(posedge clk);
      rd(ssadc_pkg::ADDR_STATUS, 8'h80);
      chk(irq, 1'b1);
      wr(ssadc_pkg::ADDR_STATUS, 8'h20);
      settle();
      chk(irq, 1'b0);
   endtask
   task automatic t_mode3();
      wr(ssadc_pkg::ADDR_CONTROL, 8'h60);
      cmp_req <= 1'b1;
      @(posedge clk);
      cmp_req <= 1'b0;
      settle();
      chk({6'h0, ramp}, 8'h00);
      wr(ssadc_pkg::ADDR_CONTROL, 8'h64);
      settle();
      chk({6'h0, ramp}, 8'h01);
      cmp_req <= 1'b1;
      @(posedge clk);
      cmp_req <= 1'b0;
      for (i = 0; i < 40 && ramp.source_on !== 1'b1; i++) @(posedge clk);
      bound();
      rd(ssadc_pkg::ADDR_CONTROL, 8'hF4);
   endtask
   task automatic t_swap();
      wr(ssadc_pkg::ADDR_CHANNEL, 8'h20);
      wr(ssadc_pkg::ADDR_STATUS, 8'h30);
      aux_in <= 1'b1;
      repeat (8) @(posedge clk);
      rd(ssadc_pkg::ADDR_STATUS, 8'h41);
      chk({swap, irq}, 8'h02);
      aux_in <= 1'b0;
      wr(ssadc_pkg::ADDR_STATUS, 8'h10);
      repeat (6) @(posedge clk);
      rd(ssadc_pkg::ADDR_STATUS, 8'h00);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_route();
      t_ramp();
      t_mode2();
      t_mode3();
      t_swap();
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* test/ssadc_timer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// timer events seen by the block
// ****************************************
module ssadc_timer_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic capture_in,
   input  wire logic compare_req,
   output logic      capture_event,
   output logic      compare_event
);
   logic cap_prev_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cap_prev_q    <= 1'b0;
         capture_event <= 1'b0;
         compare_event <= 1'b0;
      end else begin
         cap_prev_q    <= capture_in;
         capture_event <= capture_in & ~cap_prev_q;
         compare_event <= compare_req;
      end
   end
endmodule
`default_nettype wire
